// File: test/sso_mem_model.sv
// stack memory partner: word store answering each request after lat idle cycles
// assumes the core holds a request until it sees the answer
`timescale 1ns/1ps
module sso_mem_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  lat,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    output logic             ack,
    output logic      [15:0] rdata
);
    logic [15:0] mem [0:65535];
    logic [3:0]  wait_q;
    // read data toggles every cycle except when answering a read
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack    <= 1'b0;
            rdata  <= 16'h0000;
            wait_q <= 4'h0;
        end else if (req && !ack && wait_q >= lat) begin
            ack    <= 1'b1;
            wait_q <= 4'h0;
            if (we) begin
                mem[addr] <= wdata;
                rdata     <= ~rdata;
            end else begin
                rdata <= mem[addr];
            end
        end else begin
            ack    <= 1'b0;
            rdata  <= ~rdata;
            wait_q <= req ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule

// File: test/stack_and_shift_ops_tb.sv
// bench for the stack and shift unit with a memory partner
// assumes inputs driven on the falling edge, one command at a time
`timescale 1ns/1ps
module stack_and_shift_ops_tb;
    logic                clk;
    logic                rst;
    logic                clk_en;
    logic                cmd_valid;
    sso_pkg::sso_op_type cmd_op;
    logic                cmd_byte;
    logic                cmd_dst_is_reg;
    logic [15:0]         cmd_operand;
    logic [15:0]         mem_rdata;
    logic                mem_ack;
    logic                busy_q;
    logic                done_q;
    logic [15:0]         result_q;
    logic [15:0]         stack_pointer_q;
    logic [15:0]         status_word_q;
    logic [15:0]         pc_q;
    logic                mem_req_q;
    logic                mem_we_q;
    logic                mem_byte_q;
    logic [15:0]         mem_addr_q;
    logic [15:0]         mem_wdata_q;
    logic                wdt_violation_q;
    logic [3:0]          lat;
    logic                stall_en;
    int                  err_total = 0;
    int                  comparisons = 0;
    int                  wdt_cnt = 0;

    sso_core u_dut (.clk(clk), .rst(rst), .clk_en(clk_en), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_byte(cmd_byte), .cmd_dst_is_reg(cmd_dst_is_reg),
        .cmd_operand(cmd_operand), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .busy_q(busy_q), .done_q(done_q), .result_q(result_q),
        .stack_pointer_q(stack_pointer_q), .status_word_q(status_word_q), .pc_q(pc_q),
        .mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_byte_q(mem_byte_q),
        .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
        .wdt_violation_q(wdt_violation_q));

    sso_mem_model u_mem (.clk(clk), .rst(rst), .lat(lat), .req(mem_req_q), .we(mem_we_q),
        .addr(mem_addr_q), .wdata(mem_wdata_q), .ack(mem_ack), .rdata(mem_rdata));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (wdt_violation_q === 1'b1) begin
            wdt_cnt <= wdt_cnt + 1;
        end
    end

    task automatic complete_run();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    // one command, waiting for done under a bound; optional clock-enable freeze
    task automatic run(input sso_pkg::sso_op_type op, input logic b, input logic r,
                       input logic [15:0] d);
        int n;
        cmd_op = op;
        cmd_byte = b;
        cmd_dst_is_reg = r;
        cmd_operand = d;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        if (stall_en) begin
            clk_en = 1'b0;
            repeat (3) @(negedge clk);
            chk("frozen busy", 16'h0001, {15'h0000, busy_q});
            clk_en = 1'b1;
        end
        n = 0;
        while (done_q !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("done", 16'h0001, {15'h0000, done_q});
        @(negedge clk);
    endtask

    // expected {v, n, z, c, result} of a one-place shift
    function automatic logic [19:0] shx(input sso_pkg::sso_op_type op, input logic b,
                                        input logic r, input logic [15:0] d, input logic ci);
        logic [15:0] s;
        logic        cin;
        logic        c;
        logic        v;
        cin = (op == sso_pkg::SSO_OP_ROL) ? ci : 1'b0;
        if (op == sso_pkg::SSO_OP_SHR) begin
            s = b ? {8'h00, d[7], d[7:1]} : {d[15], d[15:1]};
            c = d[0];
            v = 1'b0;
        end else begin
            s = b ? {8'h00, d[6:0], cin} : {d[14:0], cin};
            c = b ? d[7] : d[15];
            v = b ? (d[7:0] >= 8'h40 && d[7:0] < 8'hC0) : (d >= 16'h4000 && d < 16'hC000);
        end
        if (b && !r) begin
            s[15:8] = d[15:8];
        end
        return {v, b ? s[7] : s[15], b ? (s[7:0] == 8'h00) : (s == 16'h0000), c, s};
    endfunction

    task automatic t_reset();
        chk("sp", 16'h0A00, stack_pointer_q);
        chk("status", 16'h0000, status_word_q);
        chk("pc", 16'h0000, pc_q);
        chk("busy", 16'h0000, {15'h0000, busy_q});
        chk("mem req", 16'h0000, {15'h0000, mem_req_q});
        chk("done", 16'h0000, {15'h0000, done_q});
        $display("test reset ended");
    endtask

    task automatic t_shift();
        logic [15:0] ops [12] = '{16'h3FFF, 16'h4000, 16'hBFFF, 16'hC000, 16'h8000, 16'h0001,
                                 16'h123F, 16'h3440, 16'h56BF, 16'hABC0, 16'h0180, 16'h7F00};
        logic [15:0]         sw;
        logic [19:0]         e;
        sso_pkg::sso_op_type op;
        for (int k = 0; k < 3; k++) begin
            op = k == 0 ? sso_pkg::SSO_OP_SHL : k == 1 ? sso_pkg::SSO_OP_ROL : sso_pkg::SSO_OP_SHR;
            for (int i = 0; i < 24; i++) begin
                sw = i[0] ? 16'h0039 : 16'h0106;
                run(sso_pkg::SSO_OP_LOAD_SW, 1'b0, 1'b0, sw);
                run(op, i >= 12, i[1], ops[i % 12]);
                e = shx(op, i >= 12, i[1], ops[i % 12], sw[0]);
                chk("shift result", e[15:0], result_q);
                chk("shift status", {sw[15:9], e[19], sw[7:3], e[18:16]}, status_word_q);
            end
        end
        $display("test shift ended");
    endtask

    task automatic t_stack();
        lat = 4'h2;
        run(sso_pkg::SSO_OP_LOAD_SW, 1'b0, 1'b0, 16'h013F);
        run(sso_pkg::SSO_OP_PUSH, 1'b0, 1'b0, 16'hBEEF);
        chk("sp", 16'h09FE, stack_pointer_q);
        chk("stack word", 16'hBEEF, u_mem.mem[16'h09FE]);
        run(sso_pkg::SSO_OP_PUSH, 1'b1, 1'b0, 16'h12F0);
        chk("sp", 16'h09FC, stack_pointer_q);
        chk("stack word", 16'h12F0, u_mem.mem[16'h09FC]);
        chk("mem byte", 16'h0001, {15'h0000, mem_byte_q});
        run(sso_pkg::SSO_OP_POP, 1'b1, 1'b1, 16'h5555);
        chk("pop result", 16'h00F0, result_q);
        chk("sp", 16'h09FE, stack_pointer_q);
        run(sso_pkg::SSO_OP_POP, 1'b1, 1'b0, 16'hAA00);
        chk("pop result", 16'hAAEF, result_q);
        chk("sp", 16'h0A00, stack_pointer_q);
        run(sso_pkg::SSO_OP_PUSH, 1'b0, 1'b0, 16'h7777);
        run(sso_pkg::SSO_OP_POP, 1'b0, 1'b1, 16'h0000);
        chk("pop result", 16'h7777, result_q);
        run(sso_pkg::SSO_OP_PUSH, 1'b0, 1'b0, 16'h4444);
        run(sso_pkg::SSO_OP_SUB_EXIT, 1'b0, 1'b0, 16'h0000);
        chk("pc", 16'h4444, pc_q);
        chk("sp", 16'h0A00, stack_pointer_q);
        chk("status", 16'h013F, status_word_q);
        $display("test stack ended");
    endtask

    task automatic t_irq();
        lat = 4'h3;
        run(sso_pkg::SSO_OP_PUSH, 1'b0, 1'b0, 16'h0200);
        run(sso_pkg::SSO_OP_PUSH, 1'b0, 1'b0, 16'h013D);
        run(sso_pkg::SSO_OP_LOAD_SW, 1'b0, 1'b0, 16'h0000);
        stall_en = 1'b1;
        run(sso_pkg::SSO_OP_IRQ_EXIT, 1'b0, 1'b0, 16'h0000);
        stall_en = 1'b0;
        chk("status", 16'h013D, status_word_q);
        chk("pc", 16'h0200, pc_q);
        chk("sp", 16'h0A00, stack_pointer_q);
        $display("test irq exit ended");
    endtask

    task automatic t_wdt();
        int n;
        lat = 4'h0;
        n = 0;
        while (stack_pointer_q !== 16'h0122 && n < 1200) begin
            run(sso_pkg::SSO_OP_PUSH, 1'b0, 1'b0, 16'h1234);
            n++;
        end
        chk("violations", 16'h0000, wdt_cnt[15:0]);
        run(sso_pkg::SSO_OP_PUSH, 1'b0, 1'b0, 16'h1234);
        chk("violations", 16'h0001, wdt_cnt[15:0]);
        run(sso_pkg::SSO_OP_POP, 1'b0, 1'b1, 16'h0000);
        run(sso_pkg::SSO_OP_PUSH, 1'b0, 1'b0, 16'h5A00);
        chk("violations", 16'h0001, wdt_cnt[15:0]);
        $display("test watchdog ended");
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        $display("watchdog span ran out");
        complete_run();
    end

    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = sso_pkg::SSO_OP_POP;
        cmd_byte = 1'b0;
        cmd_dst_is_reg = 1'b0;
        cmd_operand = 16'h0000;
        lat = 4'h0;
        stall_en = 1'b0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_shift();
        t_stack();
        t_irq();
        t_wdt();
        complete_run();
    end
endmodule

// File: verilog/sso_core.sv
// stack, subroutine exit, irq exit and shift execution unit
// assumes a memory port on the same clock that answers each request with mem_ack
`timescale 1ns/1ps
module sso_core #(
    parameter logic [7:0] WDT_KEY = 8'h5A  // arbitrary key value
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                clk_en,
    input  wire logic                cmd_valid,
    input  wire sso_pkg::sso_op_type cmd_op,
    input  wire logic                cmd_byte,
    input  wire logic                cmd_dst_is_reg,
    input  wire logic [15:0]         cmd_operand,
    input  wire logic [15:0]         mem_rdata,
    input  wire logic                mem_ack,
    output logic                     busy_q,
    output logic                     done_q,
    output logic      [15:0]         result_q,
    output logic      [15:0]         stack_pointer_q,
    output logic      [15:0]         status_word_q,
    output logic      [15:0]         pc_q,
    output logic                     mem_req_q,
    output logic                     mem_we_q,
    output logic                     mem_byte_q,
    output logic      [15:0]         mem_addr_q,
    output logic      [15:0]         mem_wdata_q,
    output logic                     wdt_violation_q
);
    sso_pkg::sso_state_type state_q;
    sso_pkg::sso_op_type    op_q;
    logic                   byte_q;
    logic                   dst_reg_q;
    logic [15:0]            operand_q;
    logic                   second_q;
    logic [15:0]            sp_at_cmd_q;
    logic [15:0]            sw_at_cmd_q;
    logic [15:0]            sh_result;
    logic                   sh_c;
    logic                   sh_v;
    logic                   sh_n;
    logic                   sh_z;
    logic                   accept;
    logic                   mem_done;

    assign accept   = clk_en && (state_q == sso_pkg::SSO_ST_IDLE) && cmd_valid;
    assign mem_done = clk_en && (state_q == sso_pkg::SSO_ST_MEM) && mem_ack;

    function automatic logic is_shift(input sso_pkg::sso_op_type op);
        is_shift = (op == sso_pkg::SSO_OP_SHL) || (op == sso_pkg::SSO_OP_ROL)
                || (op == sso_pkg::SSO_OP_SHR);
    endfunction

    sso_shift u_shift (
        .op         (op_q),
        .is_byte    (byte_q),
        .dst_is_reg (dst_reg_q),
        .operand    (operand_q),
        .carry_in   (status_word_q[sso_pkg::SSO_C_POS]),
        .result     (sh_result),
        .c_out      (sh_c),
        .v_out      (sh_v),
        .n_out      (sh_n),
        .z_out      (sh_z)
    );

    // command capture and sequencing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q     <= sso_pkg::SSO_ST_IDLE;
            op_q        <= sso_pkg::SSO_OP_POP;
            byte_q      <= 1'b0;
            dst_reg_q   <= 1'b0;
            operand_q   <= 16'h0000;
            second_q    <= 1'b0;
            sp_at_cmd_q <= sso_pkg::SSO_SP_RESET;
            sw_at_cmd_q <= sso_pkg::SSO_SW_RESET;
            busy_q      <= 1'b0;
            done_q      <= 1'b0;
        end else if (clk_en) begin
            done_q <= 1'b0;
            unique case (state_q)
                sso_pkg::SSO_ST_IDLE: begin
                    if (cmd_valid) begin
                        op_q        <= cmd_op;
                        byte_q      <= cmd_byte;
                        dst_reg_q   <= cmd_dst_is_reg;
                        operand_q   <= cmd_operand;
                        second_q    <= 1'b0;
                        sp_at_cmd_q <= stack_pointer_q;
                        sw_at_cmd_q <= status_word_q;
                        busy_q      <= 1'b1;
                        if (is_shift(cmd_op) || cmd_op == sso_pkg::SSO_OP_LOAD_SW) begin
                            state_q <= sso_pkg::SSO_ST_DONE;
                        end else begin
                            state_q <= sso_pkg::SSO_ST_MEM;
                        end
                    end
                end
                sso_pkg::SSO_ST_MEM: begin
                    if (mem_ack) begin
                        if (op_q == sso_pkg::SSO_OP_IRQ_EXIT && !second_q) begin
                            second_q <= 1'b1;  // [RL9]
                        end else begin
                            state_q <= sso_pkg::SSO_ST_DONE;
                        end
                    end
                end
                sso_pkg::SSO_ST_DONE: begin
                    state_q <= sso_pkg::SSO_ST_IDLE;
                    busy_q  <= 1'b0;
                    done_q  <= 1'b1;
                end
                default: begin
                    state_q <= sso_pkg::SSO_ST_IDLE;
                end
            endcase
        end
    end

    // stack pointer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stack_pointer_q <= sso_pkg::SSO_SP_RESET;
        end else if (clk_en) begin
            if (accept && cmd_op == sso_pkg::SSO_OP_PUSH) begin
                stack_pointer_q <= stack_pointer_q - sso_pkg::SSO_SP_STEP;  // [RL4] [RL5]
            end else if (mem_done && op_q != sso_pkg::SSO_OP_PUSH) begin
                stack_pointer_q <= stack_pointer_q + sso_pkg::SSO_SP_STEP;  // [RL1] [RL3] [RL8] [RL9]
            end
        end
    end

    // memory request port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_req_q   <= 1'b0;
            mem_we_q    <= 1'b0;
            mem_byte_q  <= 1'b0;
            mem_addr_q  <= 16'h0000;
            mem_wdata_q <= 16'h0000;
        end else if (clk_en) begin
            if (accept && !is_shift(cmd_op) && cmd_op != sso_pkg::SSO_OP_LOAD_SW) begin
                mem_req_q  <= 1'b1;
                mem_byte_q <= cmd_byte;
                if (cmd_op == sso_pkg::SSO_OP_PUSH) begin
                    mem_we_q    <= 1'b1;
                    mem_addr_q  <= stack_pointer_q - sso_pkg::SSO_SP_STEP;  // [RL4]
                    mem_wdata_q <= cmd_operand;
                end else begin
                    mem_we_q   <= 1'b0;
                    mem_addr_q <= stack_pointer_q;  // [RL1] [RL8]
                end
            end else if (mem_done) begin
                if (op_q == sso_pkg::SSO_OP_IRQ_EXIT && !second_q) begin
                    mem_addr_q <= stack_pointer_q + sso_pkg::SSO_SP_STEP;  // [RL9]
                end else begin
                    mem_req_q <= 1'b0;
                    mem_we_q  <= 1'b0;
                end
            end
        end
    end

    // destination result
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_q <= 16'h0000;
        end else if (clk_en) begin
            if (mem_done && op_q == sso_pkg::SSO_OP_POP) begin
                if (byte_q) begin
                    result_q <= {dst_reg_q ? 8'h00 : operand_q[15:8], mem_rdata[7:0]};  // [RL2]
                end else begin
                    result_q <= mem_rdata;  // [RL1]
                end
            end else if (state_q == sso_pkg::SSO_ST_DONE && is_shift(op_q)) begin
                result_q <= sh_result;
            end
        end
    end

    // status word: flags only change on shifts, irq exit and explicit loads [RL6]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_word_q <= sso_pkg::SSO_SW_RESET;
        end else if (clk_en) begin
            if (state_q == sso_pkg::SSO_ST_DONE && op_q == sso_pkg::SSO_OP_LOAD_SW) begin
                status_word_q <= operand_q;
            end else if (mem_done && op_q == sso_pkg::SSO_OP_IRQ_EXIT && !second_q) begin
                status_word_q <= mem_rdata;  // [RL10]
            end else if (state_q == sso_pkg::SSO_ST_DONE && is_shift(op_q)) begin
                status_word_q[sso_pkg::SSO_C_POS] <= sh_c;  // [RL7] mode bits untouched
                status_word_q[sso_pkg::SSO_Z_POS] <= sh_z;
                status_word_q[sso_pkg::SSO_N_POS] <= sh_n;
                status_word_q[sso_pkg::SSO_V_POS] <= sh_v;
            end
        end
    end

    // program counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_q <= sso_pkg::SSO_PC_RESET;
        end else if (clk_en && mem_done) begin
            if (op_q == sso_pkg::SSO_OP_SUB_EXIT
                || (op_q == sso_pkg::SSO_OP_IRQ_EXIT && second_q)) begin
                pc_q <= mem_rdata;  // [RL8] [RL9]
            end
        end
    end

    // watchdog control write check
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_violation_q <= 1'b0;
        end else if (clk_en) begin
            wdt_violation_q <= mem_done && mem_we_q && mem_addr_q == sso_pkg::SSO_WDT_ADDR
                               && mem_wdata_q[15:8] != WDT_KEY;  // [RL20]
        end
    end

    property p_pop_sp;
        @(posedge clk) disable iff (rst)
        (done_q && op_q == sso_pkg::SSO_OP_POP)
            |-> stack_pointer_q == sp_at_cmd_q + sso_pkg::SSO_SP_STEP;
    endproperty
    a_pop_sp: assert property (p_pop_sp) else $error("pop stack step wrong"); // [RL1] [RL3]

    property p_pop_byte;
        @(posedge clk) disable iff (rst)
        (done_q && op_q == sso_pkg::SSO_OP_POP && byte_q && dst_reg_q)
            |-> result_q[15:8] == 8'h00;
    endproperty
    a_pop_byte: assert property (p_pop_byte) else $error("byte pop high byte set"); // [RL2]

    property p_push_addr;
        @(posedge clk) disable iff (rst)
        (mem_req_q && mem_we_q)
            |-> mem_addr_q == stack_pointer_q
                && stack_pointer_q == sp_at_cmd_q - sso_pkg::SSO_SP_STEP;
    endproperty
    a_push_addr: assert property (p_push_addr) else $error("push address wrong"); // [RL4] [RL5]

    property p_flags_kept;
        @(posedge clk) disable iff (rst)
        (done_q && (op_q == sso_pkg::SSO_OP_POP || op_q == sso_pkg::SSO_OP_PUSH
                    || op_q == sso_pkg::SSO_OP_SUB_EXIT))
            |-> status_word_q == sw_at_cmd_q;
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed"); // [RL6]

    property p_mode_kept;
        @(posedge clk) disable iff (rst)
        (done_q && (is_shift(op_q) || op_q == sso_pkg::SSO_OP_PUSH))
            |-> (status_word_q & sso_pkg::SSO_MODE_MASK) == (sw_at_cmd_q & sso_pkg::SSO_MODE_MASK);
    endproperty
    a_mode_kept: assert property (p_mode_kept) else $error("mode bits changed"); // [RL7]

    property p_ret_sp;
        @(posedge clk) disable iff (rst)
        (done_q && op_q == sso_pkg::SSO_OP_SUB_EXIT)
            |-> stack_pointer_q == sp_at_cmd_q + sso_pkg::SSO_SP_STEP;
    endproperty
    a_ret_sp: assert property (p_ret_sp) else $error("return stack step wrong"); // [RL8]

    property p_irq_exit_sp;
        @(posedge clk) disable iff (rst)
        (done_q && op_q == sso_pkg::SSO_OP_IRQ_EXIT)
            |-> stack_pointer_q == sp_at_cmd_q + 16'h0004;
    endproperty
    a_irq_exit_sp: assert property (p_irq_exit_sp) else $error("irq exit stack step wrong"); // [RL9]

    property p_shl_v;
        @(posedge clk) disable iff (rst)
        (done_q && !byte_q && (op_q == sso_pkg::SSO_OP_SHL || op_q == sso_pkg::SSO_OP_ROL))
            |-> status_word_q[sso_pkg::SSO_V_POS]
                == (operand_q >= 16'h4000 && operand_q < 16'hC000)
                && status_word_q[sso_pkg::SSO_C_POS] == operand_q[15];
    endproperty
    a_shl_v: assert property (p_shl_v) else $error("left shift flags wrong"); // [RL12] [RL15]

    property p_shr;
        @(posedge clk) disable iff (rst)
        (done_q && op_q == sso_pkg::SSO_OP_SHR)
            |-> !status_word_q[sso_pkg::SSO_V_POS]
                && status_word_q[sso_pkg::SSO_C_POS] == operand_q[0];
    endproperty
    a_shr: assert property (p_shr) else $error("right shift flags wrong"); // [RL18]

    property p_wdt;
        @(posedge clk) disable iff (rst)
        (clk_en && mem_done && mem_we_q && mem_addr_q == 16'h0120
         && mem_wdata_q[15:8] != WDT_KEY) |=> wdt_violation_q;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog violation missed"); // [RL20]

    c_pop:  cover property (@(posedge clk) done_q && op_q == sso_pkg::SSO_OP_POP);
    c_push: cover property (@(posedge clk) done_q && op_q == sso_pkg::SSO_OP_PUSH);
    c_irq_exit: cover property (@(posedge clk) done_q && op_q == sso_pkg::SSO_OP_IRQ_EXIT);
    c_rol:  cover property (@(posedge clk) done_q && op_q == sso_pkg::SSO_OP_ROL && byte_q);
endmodule

// File: verilog/sso_pkg.sv
// stack and shift execution unit: shared constants and types
// assumes one 10 MHz core clock and a word-wide memory port on the same clock
// Functional notes
// RL1: pop reads word at stack pointer into destination, then stack pointer plus two.
// RL2: byte pop into register loads low byte, register high byte becomes zero.
// RL3: byte pop still advances stack pointer by two.
// RL4: push lowers stack pointer by two, then writes source at new address.
// RL5: byte push still lowers stack pointer by two.
// RL6: pop, push, subroutine exit keep negative, zero, carry, overflow flags.
// RL7: push and shifts keep oscillator-off, core-halt, interrupt-enable bits.
// RL8: subroutine exit loads program counter from stack, then stack pointer plus two.
// RL9: irq exit pops status word, then program counter, each adding two.
// RL10: irq exit restores all four flags and three mode bits from stack.
// RL11: shift left moves bits up, old top bit to carry, zero in.
// RL12: word left shifts set overflow when operand in 4000h..BFFFh.
// RL13: byte left shifts set overflow when operand in 40h..BFh.
// RL14: shifts set negative from result sign, zero when result is zero.
// RL15: left shifts load carry from operand top bit before shifting.
// RL16: rotate left puts old carry into bit zero, top bit to carry.
// RL17: shift right keeps top bit, copies it down, bit zero to carry.
// RL18: shift right clears overflow, carry from operand bit zero.
// RL19: byte shift right of register uses low byte, clears high byte.
// RL20: write to watchdog control at 120h without key flags a violation.
// RL21: byte operations use bit 7 for sign, carry and overflow.
// RL22: byte left shifts of a register clear the high byte.
package sso_pkg;

    typedef enum logic [2:0] {
        SSO_OP_POP,
        SSO_OP_PUSH,
        SSO_OP_SUB_EXIT,
        SSO_OP_IRQ_EXIT,
        SSO_OP_SHL,
        SSO_OP_ROL,
        SSO_OP_SHR,
        SSO_OP_LOAD_SW
    } sso_op_type;

    typedef enum logic [1:0] {
        SSO_ST_IDLE,
        SSO_ST_MEM,
        SSO_ST_DONE
    } sso_state_type;

    localparam int          SSO_C_POS        = 0;
    localparam int          SSO_Z_POS        = 1;
    localparam int          SSO_N_POS        = 2;
    localparam int          SSO_GIE_POS      = 3;
    localparam int          SSO_HALT_POS     = 4;
    localparam int          SSO_OSC_POS      = 5;
    localparam int          SSO_V_POS        = 8;
    localparam logic [15:0] SSO_FLAG_MASK    = 16'h0107;
    localparam logic [15:0] SSO_MODE_MASK    = 16'h0038;
    localparam logic [15:0] SSO_SP_STEP      = 16'h0002;
    localparam logic [15:0] SSO_SP_RESET     = 16'h0A00;
    localparam logic [15:0] SSO_SW_RESET     = 16'h0000;
    localparam logic [15:0] SSO_PC_RESET     = 16'h0000;
    localparam logic [15:0] SSO_WDT_ADDR     = 16'h0120;
    localparam logic [15:0] SSO_VW_LO        = 16'h4000;
    localparam logic [15:0] SSO_VW_HI        = 16'hC000;
    localparam logic [7:0]  SSO_VB_LO        = 8'h40;
    localparam logic [7:0]  SSO_VB_HI        = 8'hC0;

endpackage

// File: verilog/sso_shift.sv
// one-place shift and rotate datapath with flag results
// assumes operand and carry held stable by the caller
`timescale 1ns/1ps
module sso_shift (
    input  wire sso_pkg::sso_op_type op,
    input  wire logic                is_byte,
    input  wire logic                dst_is_reg,
    input  wire logic [15:0]         operand,
    input  wire logic                carry_in,
    output logic      [15:0]         result,
    output logic                     c_out,
    output logic                     v_out,
    output logic                     n_out,
    output logic                     z_out
);
    logic [7:0] lo;
    logic [7:0] hi_keep;

    always_comb begin
        lo      = operand[7:0];
        hi_keep = dst_is_reg ? 8'h00 : operand[15:8];  // [RL19] [RL22]
        result  = operand;
        c_out   = carry_in;
        v_out   = 1'b0;
        if (is_byte) begin
            unique case (op)
                sso_pkg::SSO_OP_SHL, sso_pkg::SSO_OP_ROL: begin
                    result = {hi_keep, lo[6:0],
                              (op == sso_pkg::SSO_OP_ROL) ? carry_in : 1'b0};  // [RL16] [RL11]
                    c_out  = lo[7];  // [RL21] [RL15]
                    v_out  = (lo >= sso_pkg::SSO_VB_LO) && (lo < sso_pkg::SSO_VB_HI);  // [RL13]
                end
                sso_pkg::SSO_OP_SHR: begin
                    result = {hi_keep, lo[7], lo[7:1]};  // [RL17] [RL19]
                    c_out  = lo[0];  // [RL18]
                end
                default: begin
                    result = operand;
                end
            endcase
            n_out = result[7];  // [RL21] [RL14]
            z_out = (result[7:0] == 8'h00);
        end else begin
            unique case (op)
                sso_pkg::SSO_OP_SHL, sso_pkg::SSO_OP_ROL: begin
                    result = {operand[14:0],
                              (op == sso_pkg::SSO_OP_ROL) ? carry_in : 1'b0};  // [RL11] [RL16]
                    c_out  = operand[15];  // [RL15]
                    v_out  = (operand >= sso_pkg::SSO_VW_LO) && (operand < sso_pkg::SSO_VW_HI);  // [RL12]
                end
                sso_pkg::SSO_OP_SHR: begin
                    result = {operand[15], operand[15:1]};  // [RL17]
                    c_out  = operand[0];  // [RL18]
                end
                default: begin
                    result = operand;
                end
            endcase
            n_out = result[15];  // [RL14]
            z_out = (result == 16'h0000);
        end
    end
endmodule
